//--- rtl/vbwd_pkg.sv
// Package with register map, field positions, reset values and routing types of the bridge window decoder.
`default_nettype none
package vbwd_pkg;
    localparam logic [7:0] IDX_CMD = 8'h04;
    localparam logic [7:0] IDX_IO_BOTTOM = 8'h1C;
    localparam logic [7:0] IDX_IO_TOP = 8'h1D;
    localparam logic [7:0] IDX_SEC_STS = 8'h1E;
    localparam logic [7:0] IDX_MEM_BOTTOM = 8'h20;
    localparam logic [7:0] IDX_MEM_TOP = 8'h22;
    localparam logic [7:0] IDX_PF_BOTTOM = 8'h24;
    localparam logic [7:0] IDX_PF_TOP = 8'h26;
    localparam logic [7:0] IDX_BCTRL = 8'h3E;
    localparam logic [7:0] IDX_ERRCMD = 8'h40;
    localparam logic [7:0] IDX_HUB_CFG = 8'hC6;
    localparam logic [15:0] CMD_RST = 16'h0000;
    localparam logic [15:0] STS_RST = 16'h0000;
    localparam logic [7:0] HUB_RST = 8'h00;
    localparam logic [15:0] CMD_MASK = 16'h0103;
    localparam logic [7:0] HUB_MASK = 8'h01;
    // Each register sits in its own word, four bytes per index.
    function automatic logic [9:0] vbwd_addr(input logic [7:0] idx);
        vbwd_addr = {idx, 2'b00};
    endfunction : vbwd_addr
    localparam logic [15:0] MEM_TOP_RST = 16'h0000;
    localparam logic [15:0] PF_BOTTOM_RST = 16'hFFF0;
    localparam logic [15:0] PF_TOP_RST = 16'h0000;
    localparam logic [15:0] MEM_BOTTOM_RST = 16'hFFF0;
    localparam logic [7:0] IO_BOTTOM_RST = 8'hF0;
    localparam logic [7:0] IO_TOP_RST = 8'h00;
    localparam logic [7:0] BCTRL_RST = 8'h00;
    localparam logic [7:0] ERRCMD_RST = 8'h00;
    localparam logic [15:0] WIN_MASK = 16'hFFF0;
    localparam logic [7:0] IO_NIB_MASK = 8'hF0;
    localparam logic [7:0] BCTRL_MASK = 8'h0D;
    localparam logic [7:0] ERRCMD_MASK = 8'h01;
    localparam int BC_PARITY = 0;
    localparam int BC_ALIAS = 2;
    localparam int BC_VIDEO = 3;
    localparam int EC_TA = 0;
    localparam int CMD_SERR = 8;
    localparam int ST_TA = 12;
    localparam int ST_MA = 13;
    localparam int HC_MONO = 0;
    localparam logic [19:0] LOW_ONES = 20'hFFFFF;
    localparam logic [19:0] LOW_ZERO = 20'h00000;
    localparam logic [11:0] IO_LOW_ONES = 12'hFFF;
    localparam logic [11:0] IO_LOW_ZERO = 12'h000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [31:0] ALL_ONES = 32'hFFFFFFFF;
    typedef enum logic [1:0] {VBWD_NONE, VBWD_SEC_NP, VBWD_SEC_PF, VBWD_HUB} vbwd_route_t;
    typedef struct packed {
        logic valid;
        logic is_io;
        logic is_video;
        logic is_mono;
        logic [31:0] addr;
    } vbwd_cycle_t;
    typedef struct packed {
        logic valid;
        vbwd_route_t route;
    } vbwd_dest_t;
    typedef struct packed {
        logic parity_err;
        logic target_abort;
        logic master_abort;
        logic other_err;
    } vbwd_err_t;
endpackage : vbwd_pkg
`default_nettype wire

//--- rtl/vbwd_top.sv
// Bridge window decoder: AXI4-Lite registers, cycle routing and error messaging.
`default_nettype none
// Overview of operation
// - memory window bits 15:4 writable, I/O window bits 7:4, low nibble zero
// - limit compare uses low address ones
// - prefetch base compare uses low zeros
// - memory window hit goes non-prefetchable
// - prefetch window hit goes prefetchable
// - master abort drops writes, reads ones
// - bridge control bits 7:4,1 read zero
// - video enable routes video secondary, mono hub
// - both clear routes legacy to hub
// - alias filter clear forwards whole window
// - alias filter set sends upper 768 hub
// - parity enable clear suppresses parity messages
// - parity message needs global enable too
// - target abort message when its enable and global enable set
// - target abort flag set, write-one clear
// - master abort flag set, write-one clear
module vbwd_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire vbwd_pkg::vbwd_cycle_t cycle_in,
    output vbwd_pkg::vbwd_dest_t dest_out,
    input wire vbwd_pkg::vbwd_err_t sec_err,
    input wire logic sec_is_read,
    input wire logic [31:0] sec_rdata,
    output logic [31:0] sec_rdata_out,
    output logic sec_write_commit,
    output logic hub_syserr_msg
);
    import vbwd_pkg::*;

    logic rst_meta, rst_sync;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    logic [15:0] mem_window_top;
    logic [15:0] pf_window_bottom;
    logic [15:0] pf_window_top;
    logic [15:0] mem_window_bottom;
    logic [7:0] io_window_bottom;
    logic [7:0] io_window_top;
    logic [7:0] secondary_bridge_control;
    logic [7:0] error_message_control;
    logic [15:0] primary_command;
    logic [15:0] secondary_status;
    logic [7:0] hub_config;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                            input logic [1:0] be, input logic [15:0] mask);
        logic [15:0] r;
        r = old;
        if (be[0]) r[7:0] = nw[7:0];
        if (be[1]) r[15:8] = nw[15:8];
        merge16 = r & mask;
    endfunction : merge16

    function automatic logic [7:0] merge8(input logic [7:0] old, input logic [7:0] nw,
                                          input logic be, input logic [7:0] mask);
        merge8 = be ? (nw & mask) : old;
    endfunction : merge8

    function automatic logic reg_known(input logic [7:0] idx);
        case (idx)
            IDX_CMD: reg_known = 1'b1;
            IDX_IO_BOTTOM: reg_known = 1'b1;
            IDX_IO_TOP: reg_known = 1'b1;
            IDX_SEC_STS: reg_known = 1'b1;
            IDX_MEM_BOTTOM: reg_known = 1'b1;
            IDX_MEM_TOP: reg_known = 1'b1;
            IDX_PF_BOTTOM: reg_known = 1'b1;
            IDX_PF_TOP: reg_known = 1'b1;
            IDX_BCTRL: reg_known = 1'b1;
            IDX_ERRCMD: reg_known = 1'b1;
            IDX_HUB_CFG: reg_known = 1'b1;
            default: reg_known = 1'b0;
        endcase
    endfunction : reg_known

    logic aw_held, w_held;
    logic [9:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_held && w_held && !s_axi_bvalid;
    wire [7:0] wr_idx = aw_addr[9:2];
    wire wr_cmd = wr_go && wr_idx == IDX_CMD;
    wire wr_io_bottom = wr_go && wr_idx == IDX_IO_BOTTOM;
    wire wr_io_top = wr_go && wr_idx == IDX_IO_TOP;
    wire wr_sec_sts = wr_go && wr_idx == IDX_SEC_STS;
    wire wr_mem_bottom = wr_go && wr_idx == IDX_MEM_BOTTOM;
    wire wr_mem_top = wr_go && wr_idx == IDX_MEM_TOP;
    wire wr_pf_bottom = wr_go && wr_idx == IDX_PF_BOTTOM;
    wire wr_pf_top = wr_go && wr_idx == IDX_PF_TOP;
    wire wr_bctrl = wr_go && wr_idx == IDX_BCTRL;
    wire wr_errcmd = wr_go && wr_idx == IDX_ERRCMD;
    wire wr_hub = wr_go && wr_idx == IDX_HUB_CFG;
    wire wr_hit = reg_known(wr_idx);

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 10'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held && !aw_take;
            s_axi_wready <= !w_held && !w_take;
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    wire ta_clear = wr_sec_sts && w_strb[1] && w_data[ST_TA];
    wire ma_clear = wr_sec_sts && w_strb[1] && w_data[ST_MA];
    wire ma_event = sec_err.master_abort;
    wire ta_event = sec_err.target_abort;

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            mem_window_bottom <= MEM_BOTTOM_RST;
            mem_window_top <= MEM_TOP_RST;
        end else begin
            if (wr_mem_bottom) mem_window_bottom <= merge16(mem_window_bottom, w_data[15:0], w_strb[1:0], WIN_MASK);
            if (wr_mem_top) mem_window_top <= merge16(mem_window_top, w_data[15:0], w_strb[1:0], WIN_MASK);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            pf_window_bottom <= PF_BOTTOM_RST;
            pf_window_top <= PF_TOP_RST;
        end else begin
            if (wr_pf_bottom) pf_window_bottom <= merge16(pf_window_bottom, w_data[15:0], w_strb[1:0], WIN_MASK);
            if (wr_pf_top) pf_window_top <= merge16(pf_window_top, w_data[15:0], w_strb[1:0], WIN_MASK);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            io_window_bottom <= IO_BOTTOM_RST;
            io_window_top <= IO_TOP_RST;
        end else begin
            if (wr_io_bottom) io_window_bottom <= merge8(io_window_bottom, w_data[7:0], w_strb[0], IO_NIB_MASK);
            if (wr_io_top) io_window_top <= merge8(io_window_top, w_data[7:0], w_strb[0], IO_NIB_MASK);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            secondary_bridge_control <= BCTRL_RST;
            error_message_control <= ERRCMD_RST;
        end else begin
            if (wr_bctrl) secondary_bridge_control <= merge8(secondary_bridge_control, w_data[7:0], w_strb[0], BCTRL_MASK);
            if (wr_errcmd) error_message_control <= merge8(error_message_control, w_data[7:0], w_strb[0], ERRCMD_MASK);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            primary_command <= CMD_RST;
            hub_config <= HUB_RST;
        end else begin
            if (wr_cmd) primary_command <= merge16(primary_command, w_data[15:0], w_strb[1:0], CMD_MASK);
            if (wr_hub) hub_config <= merge8(hub_config, w_data[7:0], w_strb[0], HUB_MASK);
        end
    end

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            secondary_status <= STS_RST;
        end else begin
            secondary_status[ST_TA] <= ta_event | (secondary_status[ST_TA] & ~ta_clear);
            secondary_status[ST_MA] <= ma_event | (secondary_status[ST_MA] & ~ma_clear);
        end
    end

    wire [7:0] rd_idx = s_axi_araddr[9:2];
    wire rd_known = reg_known(rd_idx);
    wire [31:0] rd_value =
        rd_idx == IDX_CMD ? {16'h0000, primary_command} :
        rd_idx == IDX_IO_BOTTOM ? {24'h000000, io_window_bottom} :
        rd_idx == IDX_IO_TOP ? {24'h000000, io_window_top} :
        rd_idx == IDX_SEC_STS ? {16'h0000, secondary_status} :
        rd_idx == IDX_MEM_BOTTOM ? {16'h0000, mem_window_bottom} :
        rd_idx == IDX_MEM_TOP ? {16'h0000, mem_window_top} :
        rd_idx == IDX_PF_BOTTOM ? {16'h0000, pf_window_bottom} :
        rd_idx == IDX_PF_TOP ? {16'h0000, pf_window_top} :
        rd_idx == IDX_BCTRL ? {24'h000000, secondary_bridge_control} :
        rd_idx == IDX_ERRCMD ? {24'h000000, error_message_control} :
        rd_idx == IDX_HUB_CFG ? {24'h000000, hub_config} : 32'h00000000;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_value;
                s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    wire [31:0] a = cycle_in.addr;
    wire [31:0] mem_lo = {mem_window_bottom[15:4], LOW_ZERO};
    wire [31:0] mem_hi = {mem_window_top[15:4], LOW_ONES};
    wire [31:0] pf_lo = {pf_window_bottom[15:4], LOW_ZERO};
    wire [31:0] pf_hi = {pf_window_top[15:4], LOW_ONES};
    wire mem_en = primary_command[1];
    wire io_en = primary_command[0];
    wire np_hit = mem_en && a >= mem_lo && a <= mem_hi;
    wire pf_hit = mem_en && a >= pf_lo && a <= pf_hi;
    wire [15:0] io_lo = {io_window_bottom[7:4], IO_LOW_ZERO};
    wire [15:0] io_hi = {io_window_top[7:4], IO_LOW_ONES};
    wire io_hit = io_en && a[15:0] >= io_lo && a[15:0] <= io_hi;
    wire alias_hit = secondary_bridge_control[BC_ALIAS] && a[9:8] != 2'b00;
    wire video_on = secondary_bridge_control[BC_VIDEO];
    vbwd_route_t next_route;
    assign next_route =
        cycle_in.is_mono ? VBWD_HUB :
        cycle_in.is_video ? (video_on ? VBWD_SEC_NP : VBWD_HUB) :
        cycle_in.is_io ? ((io_hit && !alias_hit) ? VBWD_SEC_NP : VBWD_HUB) :
        np_hit ? VBWD_SEC_NP : pf_hit ? VBWD_SEC_PF : VBWD_NONE;

    wire serr_on = primary_command[CMD_SERR];
    wire next_msg = serr_on && ((sec_err.parity_err && secondary_bridge_control[BC_PARITY]) ||
                   (ta_event && error_message_control[EC_TA]) || sec_err.other_err);

    always_ff @(posedge mclk or negedge rst_sync) begin
        if (!rst_sync) begin
            dest_out <= '0;
            hub_syserr_msg <= 1'b0;
            sec_rdata_out <= 32'h00000000;
            sec_write_commit <= 1'b0;
        end else begin
            dest_out.valid <= cycle_in.valid;
            dest_out.route <= cycle_in.valid ? next_route : VBWD_NONE;
            hub_syserr_msg <= next_msg;
            sec_rdata_out <= ma_event ? ALL_ONES : sec_rdata;
            sec_write_commit <= !sec_is_read && !ma_event;
        end
    end
endmodule : vbwd_top
`default_nettype wire

//--- bench/vbwd_chk.sv
// Checker of the bridge window decoder ports.
`default_nettype none
module vbwd_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire vbwd_pkg::vbwd_cycle_t cycle_in,
    input wire vbwd_pkg::vbwd_dest_t dest_out,
    input wire vbwd_pkg::vbwd_err_t sec_err,
    input wire logic sec_is_read,
    input wire logic [31:0] sec_rdata_out,
    input wire logic sec_write_commit,
    input wire logic hub_syserr_msg
);
    import vbwd_pkg::*;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    wresp_due_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[0:16] s_axi_bvalid)
        else $error("write response late");
    rresp_due_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:16] s_axi_rvalid)
        else $error("read response late");
    bresp_once_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    rresp_once_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    abort_read_a: assert property ((sec_err.master_abort && sec_is_read) [*2] |-> sec_rdata_out == ALL_ONES)
        else $error("aborted read not all ones");
    abort_write_a: assert property ((sec_err.master_abort && !sec_is_read) [*2] |-> !sec_write_commit)
        else $error("aborted write committed");
    mono_hub_a: assert property ((cycle_in.valid && cycle_in.is_mono) [*2] ##0 dest_out.valid
        |-> dest_out.route == VBWD_HUB)
        else $error("mono reference not sent to hub");
    idle_dest_a: assert property ((!cycle_in.valid) [*2] |-> !dest_out.valid)
        else $error("destination without a cycle");
    quiet_err_a: assert property ((sec_err == 4'h0) [*4] |-> !hub_syserr_msg)
        else $error("error message without a cause");
endmodule : vbwd_chk
bind vbwd_top vbwd_chk u_chk (.mclk, .rst_n, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .cycle_in, .dest_out, .sec_err,
    .sec_is_read, .sec_rdata_out, .sec_write_commit, .hub_syserr_msg);
`default_nettype wire

//--- bench/vbwd_far_model.sv
// Behavioural model of the secondary bus device answering bridge cycles.
`default_nettype none
module vbwd_far_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire vbwd_pkg::vbwd_err_t want_err,
    input wire logic want_rd,
    output vbwd_pkg::vbwd_err_t sec_err,
    output logic sec_is_read,
    output logic [31:0] sec_rdata
);
    import vbwd_pkg::*;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sec_err <= 4'h0;
            sec_is_read <= 1'b0;
            sec_rdata <= 32'h5A5A0F0F;
        end else begin
            sec_err <= want_err;
            sec_is_read <= want_rd;
            // Read data never holds, so an aborted read cannot pass on stale data.
            sec_rdata <= ~sec_rdata;
        end
    end
endmodule : vbwd_far_model
`default_nettype wire

//--- bench/test_vbwd_top.sv
// Self-checking testbench of the bridge window decoder.
`default_nettype none
module test_vbwd_top;
    import vbwd_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {logic w; logic [9:0] a; logic [31:0] d, m, e;} vbwd_reg_row_t;
    typedef struct {logic [7:0] bc; logic [1:0] k; logic [31:0] a; logic [1:0] e;} vbwd_rt_row_t;
    typedef struct {logic [7:0] bc; logic cmd, ec; vbwd_err_t err; logic e;} vbwd_err_row_t;
    logic mclk = 1'b0, rst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic wrd = 1'b0, awready, wready, bvalid, arready, rvalid, srd, commit, msg;
    logic [9:0] awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, d, rdata, srdata, rdo;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] bresp, rresp, resp;
    vbwd_cycle_t cyc = '0;
    vbwd_dest_t dest;
    vbwd_err_t want = 4'h0, serr;
    int miscompares = 0, n_compared = 0, ticks = 0;
    vbwd_reg_row_t rg[10] = '{'{0, 10'h088, 0, 32'hFFFF, 0}, '{0, 10'h090, 0, 32'hFFFF, 32'hFFF0},
        '{0, 10'h098, 0, 32'hFFFF, 0}, '{0, 10'h0F8, 0, 32'hFF, 0}, '{0, 10'h100, 0, 32'hFF, 0},
        '{1, 10'h088, '1, 32'hFFFF, 32'hFFF0}, '{1, 10'h090, '1, 32'hFFFF, 32'hFFF0},
        '{1, 10'h098, '1, 32'hFFFF, 32'hFFF0}, '{1, 10'h0F8, '1, 32'hFF, 32'h0D}, '{1, 10'h100, '1, 32'hFF, 32'h01}};
    vbwd_rt_row_t rt[19] = '{'{8'h09, 0, 32'h10000000, 2}, '{8'h09, 0, 32'h10FFFFFF, 2},
        '{8'h09, 0, 32'h0FFFFFFF, 0}, '{8'h09, 0, 32'h11000000, 0}, '{8'h09, 0, 32'h20000000, 3},
        '{8'h09, 0, 32'h20FFFFFF, 3}, '{8'h09, 0, 32'h1FFFFFFF, 0}, '{8'h09, 0, 32'h21000000, 0},
        '{8'h09, 1, 32'h1000, 2}, '{8'h09, 1, 32'h2FFF, 2}, '{8'h09, 1, 32'h3000, 0},
        '{8'h0D, 1, 32'h1100, 0}, '{8'h0D, 1, 32'h13FF, 0}, '{8'h0D, 1, 32'h1000, 2},
        '{8'h0D, 1, 32'h10FF, 2}, '{8'h09, 2, 32'hA0000, 2}, '{8'h09, 3, 32'hB0000, 0},
        '{8'h00, 2, 32'hA0000, 0}, '{8'h00, 3, 32'hB0000, 0}};
    vbwd_err_row_t er[5] = '{'{8'h01, 1, 0, 4'h8, 1}, '{8'h01, 0, 0, 4'h8, 0}, '{8'h00, 1, 0, 4'h8, 0},
        '{8'h00, 1, 1, 4'h4, 1}, '{8'h00, 1, 0, 4'h4, 0}};
    vbwd_top DUT (.mclk(mclk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cycle_in(cyc), .dest_out(dest),
        .sec_err(serr), .sec_is_read(srd), .sec_rdata(srdata), .sec_rdata_out(rdo), .sec_write_commit(commit),
        .hub_syserr_msg(msg));
    vbwd_far_model u_far (.mclk(mclk), .rst_n(rst_n), .want_err(want), .want_rd(wrd), .sec_err(serr),
        .sec_is_read(srd), .sec_rdata(srdata));
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        ticks++;
        if (ticks == 5000) begin
            miscompares++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [31:0] v);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        @(posedge mclk);
    endtask : wr
    task automatic rd(input logic [9:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge mclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        @(posedge mclk);
    endtask : rd
    task automatic route(input vbwd_rt_row_t r);
        logic [1:0] got;
        wr(vbwd_addr(IDX_BCTRL), {24'h000000, r.bc});
        cyc <= '{1'b1, r.k == 2'd1, r.k == 2'd2, r.k == 2'd3, r.a};
        for (int n = 0; n < 8 && dest.valid !== 1'b1; n++) @(negedge mclk);
        got = (dest.valid === 1'b1) ? {dest.route inside {VBWD_SEC_NP, VBWD_SEC_PF}, dest.route == VBWD_SEC_PF} : 2'bxx;
        repeat (2) @(posedge mclk);
        cyc.valid <= 1'b0;
        @(posedge mclk);
        chk({30'h0, got}, {30'h0, r.e});
    endtask : route
    initial begin
        logic seen;
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        foreach (rg[i]) begin
            if (rg[i].w) wr(rg[i].a, rg[i].d);
            rd(rg[i].a);
            chk(d & rg[i].m, rg[i].e);
        end
        // Windows are kept apart from one another.
        wr(vbwd_addr(IDX_CMD), 32'h00000003);
        wr(vbwd_addr(IDX_MEM_BOTTOM), 32'h00001000);
        wr(vbwd_addr(IDX_MEM_TOP), 32'h000010F0);
        wr(vbwd_addr(IDX_PF_BOTTOM), 32'h00002000);
        wr(vbwd_addr(IDX_PF_TOP), 32'h000020F0);
        wr(vbwd_addr(IDX_IO_BOTTOM), 32'h00000010);
        wr(vbwd_addr(IDX_IO_TOP), 32'h00000020);
        wr(vbwd_addr(IDX_ERRCMD), 32'h0);
        foreach (rt[i]) route(rt[i]);
        wr(vbwd_addr(IDX_BCTRL), 32'h00000008);
        wr(vbwd_addr(IDX_HUB_CFG), 32'h1);
        route('{8'h08, 3, 32'hB0000, 0});
        route('{8'h08, 2, 32'hA0000, 2});
        wr(vbwd_addr(IDX_HUB_CFG), 32'h0);
        foreach (er[i]) begin
            wr(vbwd_addr(IDX_BCTRL), {24'h000000, er[i].bc});
            wr(vbwd_addr(IDX_CMD), {23'h0, er[i].cmd, 8'h03});
            wr(vbwd_addr(IDX_ERRCMD), {31'h0, er[i].ec});
            want <= er[i].err;
            @(posedge mclk);
            want <= 4'h0;
            seen = 1'b0;
            repeat (8) @(negedge mclk) seen |= msg;
            chk({31'h0, seen}, {31'h0, er[i].e});
        end
        want <= 4'h2;
        wrd <= 1'b1;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk(rdo, ALL_ONES);
        @(posedge mclk);
        wrd <= 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        chk({31'h0, commit}, 32'h0);
        @(posedge mclk);
        want <= 4'h0;
        rd(vbwd_addr(IDX_SEC_STS));
        chk(d & 32'h00003000, 32'h00003000);
        chk({31'h0, commit}, 32'h1);
        wr(vbwd_addr(IDX_SEC_STS), 32'h00003000);
        rd(vbwd_addr(IDX_SEC_STS));
        chk(d & 32'h00003000, 32'h0);
        rd(10'h3F0);
        chk({30'h0, resp}, {30'h0, RESP_SLVERR});
        report_and_stop();
    end
endmodule : test_vbwd_top
`default_nettype wire
